// ==== ppr_top.sv ====
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "ppr_params.svh"

// Functional notes
// R01 - supports compatibility, bidirectional, FIFO, EPP, ECP modes; extended ECP optional.
// R02 - EPP and second-level registers reachable only with 8-byte aligned base.
// R03 - offset 000h is data latch in modes 000/001, address FIFO in 011.
// R04 - offset 400h: compat FIFO 010, ECP FIFO 011, test FIFO 110, config A 111.
// R05 - offsets 003h-007h are EPP address and data ports only in mode 100.
// R06 - index bits 2-0 pick second-level register 00h,02h,04h,05h through data register.
// R07 - status read-only; line states in bits 7-3, EPP timeout in bit 0.
// R08 - extended control: mode bits 7-5, DMA enable, service, full and empty flags.
// R09 - unselected or unaligned accesses ignore writes and read a fixed value.
module ppr_top
  import ppr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [10:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire ppr_lines_t  lines_i,
  input  wire logic [7:0]  pd_i,
  output logic      [7:0]  pd_o,
  output logic             pd_oe_o,
  output logic      [3:0]  ctrl_lines_o,
  output logic             xfer_valid_o,
  output ppr_xkind_t       xfer_kind_o,
  output logic             xfer_write_o,
  output logic      [1:0]  xfer_port_o,
  output logic      [7:0]  xfer_wdata_o,
  input  wire logic        xfer_ready_i,
  input  wire logic [7:0]  xfer_rdata_i,
  input  wire logic        xfer_timeout_i,
  input  wire logic        fifo_full_i,
  input  wire logic        fifo_empty_i,
  input  wire logic        fifo_tag_i,
  output logic      [2:0]  mode_o,
  output logic             ext_ecp_o,
  output logic             dma_en_o,
  output logic             ecp_service_o,
  output logic      [7:0]  ctrl0_o,
  output logic      [7:0]  ctrl2_o,
  output logic      [7:0]  ctrl4_o,
  output logic      [7:0]  port_cfg_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ppr_regs_t s_r;
  ppr_regs_t s_nxt;
  ppr_sel_t  sel;
  logic [2:0] mode;
  logic       aligned;
  logic       bus_req;
  logic [7:0] rd_val;
  logic [7:0] sl_rd;
  logic       ack_fall;

  // ----------------------------------------------------------------
  // read views and strobes
  // ----------------------------------------------------------------
  logic       dir_rev;
  logic       to_cable;
  logic       tmo_event;
  logic       wr_commit;
  logic [7:0] dsr_val;
  logic [7:0] dcr_val;
  logic [7:0] cfga_val;
  logic [7:0] cfgb_val;
  logic [7:0] ecr_val;
  logic [7:0] ear_val;
  logic [7:0] eir_val;
  logic [7:0] setup_val;
  logic [7:0] ist_val;
  logic [7:0] imsk_val;

  assign mode    = s_r.extended_control[5:3];
  assign aligned = s_r.setup[`PPR_SET_ALIGN];
  assign bus_req = avs_read_i | avs_write_i;
  assign dir_rev = (mode == `PPR_MODE_BIDIR) && s_r.port_line_control[`PPR_DCR_DIR];
  // a write with the low byte lane off is answered but changes no local register; fifo and EPP writes still go to the cable
  assign wr_commit = avs_write_i && avs_byteenable_i[0];

  // reserved bits read as zero so software can compare whole bytes
  assign dsr_val   = {lines_i.busy, lines_i.ack, lines_i.pe, lines_i.slct, lines_i.err,
                      2'h0, s_r.timeout}; // R07
  assign dcr_val   = {2'h0, s_r.port_line_control[5:0]};
  assign cfga_val  = {4'h0, s_r.cfg0[`PPR_CFG0_CNFA], 3'h0};
  assign cfgb_val  = {1'b0, irq_o, s_r.cfg0[5:3], 1'b0, s_r.cfg0[1:0]};
  assign ecr_val   = {s_r.extended_control, fifo_full_i, fifo_empty_i}; // R08
  assign ear_val   = {fifo_tag_i, 7'h00};
  assign eir_val   = {5'h00, s_r.extended_index};
  assign setup_val = {6'h00, s_r.setup};
  assign ist_val   = {6'h00, s_r.ist};
  assign imsk_val  = {6'h00, s_r.imsk};

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always_comb
  begin
    sel = SEL_NONE;
    if (avs_address_i == `PPR_IDX_DATA)
    begin
      if (mode == `PPR_MODE_SPP || mode == `PPR_MODE_BIDIR)
        sel = SEL_DATA; // R03
      else if (mode == `PPR_MODE_ECP && avs_write_i)
        sel = SEL_ECP_ADDRESS_FIFO; // R03
    end
    else if (avs_address_i == `PPR_IDX_DSR)
      sel = SEL_DSR;
    else if (avs_address_i == `PPR_IDX_DCR)
      sel = SEL_DCR;
    else if (avs_address_i == `PPR_IDX_EPPA)
    begin
      if (mode == `PPR_MODE_EPP && aligned)
        sel = SEL_EPPA; // R05 R02
    end
    else if (avs_address_i >= `PPR_IDX_EPPD0 && avs_address_i <= `PPR_IDX_EPPD3)
    begin
      if (mode == `PPR_MODE_EPP && aligned)
        sel = SEL_EPPD; // R05 R02
    end
    else if (avs_address_i == `PPR_IDX_FIFO)
    begin
      if (mode == `PPR_MODE_FIFO && avs_write_i)
        sel = SEL_COMPAT_FIFO; // R04
      else if (mode == `PPR_MODE_ECP)
        sel = SEL_ECP_DATA_FIFO; // R04
      else if (mode == `PPR_MODE_TEST)
        sel = SEL_TEST_FIFO; // R04
      else if (mode == `PPR_MODE_CFG && avs_read_i)
        sel = SEL_CFGA; // R04
    end
    else if (avs_address_i == `PPR_IDX_CFGB)
    begin
      if (mode == `PPR_MODE_CFG && avs_read_i)
        sel = SEL_CFGB;
    end
    else if (avs_address_i == `PPR_IDX_ECR)
      sel = SEL_ECR;
    else if (avs_address_i == `PPR_IDX_EIR)
    begin
      if (aligned)
        sel = SEL_EIR; // R02
    end
    else if (avs_address_i == `PPR_IDX_EDR)
    begin
      if (aligned)
        sel = SEL_EDR; // R02
    end
    else if (avs_address_i == `PPR_IDX_EAR)
      sel = SEL_EAR;
    else if (avs_address_i == `PPR_IDX_SETUP)
      sel = SEL_SETUP;
    else if (avs_address_i == `PPR_IDX_IST)
      sel = SEL_IST;
    else if (avs_address_i == `PPR_IDX_IMSK)
      sel = SEL_IMSK;
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb
  begin
    sl_rd = `PPR_FILL;
    if (s_r.extended_index == `PPR_SL_CTRL0)
      sl_rd = s_r.ctrl0; // R06
    else if (s_r.extended_index == `PPR_SL_CTRL2)
      sl_rd = s_r.ctrl2; // R06
    else if (s_r.extended_index == `PPR_SL_CTRL4)
      sl_rd = s_r.ctrl4; // R06
    else if (s_r.extended_index == `PPR_SL_CFG0)
      sl_rd = s_r.cfg0; // R06
  end

  always_comb
  begin
    rd_val = `PPR_FILL; // R09
    case (sel)
      SEL_DATA:
        // reverse direction in bidirectional mode shows the cable
        rd_val = dir_rev ? pd_i : s_r.data_latch;
      SEL_DSR:   rd_val = dsr_val; // R07
      SEL_DCR:   rd_val = dcr_val;
      SEL_CFGA:  rd_val = cfga_val;
      SEL_CFGB:  rd_val = cfgb_val;
      SEL_ECR:   rd_val = ecr_val; // R08
      SEL_EIR:   rd_val = eir_val;
      SEL_EDR:   rd_val = sl_rd;
      SEL_EAR:   rd_val = ear_val;
      SEL_SETUP: rd_val = setup_val;
      SEL_IST:   rd_val = ist_val;
      SEL_IMSK:  rd_val = imsk_val;
      default:   rd_val = `PPR_FILL; // R09
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign ack_fall = s_r.ack_d & ~lines_i.ack;
  // fifo and EPP traffic goes out to the cable engine, the rest is local
  assign to_cable  = (sel == SEL_ECP_ADDRESS_FIFO) || (sel == SEL_COMPAT_FIFO) || (sel == SEL_ECP_DATA_FIFO) ||
                     (sel == SEL_TEST_FIFO) || (sel == SEL_EPPA) || (sel == SEL_EPPD);
  // only EPP cycles carry a timeout; fifo kinds ignore the line
  assign tmo_event = (s_r.state == ST_XFER) && xfer_ready_i && xfer_timeout_i &&
                     ((s_r.xkind == XK_EPPA) || (s_r.xkind == XK_EPPD));

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.ack_d = lines_i.ack;
    case (s_r.state)
      ST_IDLE:
      begin
        if (bus_req)
        begin
          s_nxt.xwrite = avs_write_i;
          s_nxt.xwdata = avs_writedata_i[7:0];
          s_nxt.xport  = avs_address_i[1:0];
          s_nxt.rdata  = rd_val;
          if (to_cable)
          begin
            s_nxt.state = ST_XFER;
            if (sel == SEL_ECP_ADDRESS_FIFO)
              s_nxt.xkind = XK_ECP_ADDRESS_FIFO;
            else if (sel == SEL_COMPAT_FIFO)
              s_nxt.xkind = XK_COMPAT_FIFO;
            else if (sel == SEL_ECP_DATA_FIFO)
              s_nxt.xkind = XK_ECP_DATA_FIFO;
            else if (sel == SEL_TEST_FIFO)
              s_nxt.xkind = XK_TEST_FIFO;
            else if (sel == SEL_EPPA)
              s_nxt.xkind = XK_EPPA; // R05
            else
              s_nxt.xkind = XK_EPPD; // R05
          end
          else
          begin
            s_nxt.state = ST_DONE;
            // reading status acknowledges the timeout flag
            if (avs_read_i && sel == SEL_DSR)
              s_nxt.timeout = 1'b0;
          end
        end
      end
      ST_XFER:
      begin
        if (xfer_ready_i)
        begin
          s_nxt.rdata = s_r.xwrite ? `PPR_ZERO : xfer_rdata_i;
          s_nxt.state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        s_nxt.state = ST_IDLE;
        if (wr_commit)
        begin
          if (sel == SEL_DATA)
            s_nxt.data_latch = avs_writedata_i[7:0]; // R03
          else if (sel == SEL_DCR)
            s_nxt.port_line_control = avs_writedata_i[7:0];
          else if (sel == SEL_ECR)
            s_nxt.extended_control = avs_writedata_i[7:2]; // R08
          else if (sel == SEL_EIR)
            s_nxt.extended_index = avs_writedata_i[2:0]; // R06
          else if (sel == SEL_EDR)
          begin
            if (s_r.extended_index == `PPR_SL_CTRL0)
              s_nxt.ctrl0 = avs_writedata_i[7:0]; // R06
            else if (s_r.extended_index == `PPR_SL_CTRL2)
              s_nxt.ctrl2 = avs_writedata_i[7:0]; // R06
            else if (s_r.extended_index == `PPR_SL_CTRL4)
              s_nxt.ctrl4 = avs_writedata_i[7:0]; // R06
            else if (s_r.extended_index == `PPR_SL_CFG0)
              s_nxt.cfg0 = avs_writedata_i[7:0]; // R06
          end
          else if (sel == SEL_SETUP)
            s_nxt.setup = avs_writedata_i[1:0]; // R01 R02
          else if (sel == SEL_IST)
            s_nxt.ist = s_r.ist & ~avs_writedata_i[1:0];
          else if (sel == SEL_IMSK)
            s_nxt.imsk = avs_writedata_i[1:0];
        end
      end
      default:
        s_nxt.state = ST_IDLE;
    endcase

    // events land after the clears so a same-cycle event is never lost
    if (tmo_event)
    begin
      s_nxt.timeout            = 1'b1; // R07
      s_nxt.ist[`PPR_IST_TMO]  = 1'b1;
    end
    if (ack_fall && s_r.port_line_control[`PPR_DCR_IEN])
      s_nxt.ist[`PPR_IST_ACK] = 1'b1;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_r.state      <= ST_IDLE;
      s_r.rdata      <= `PPR_RST_BYTE;
      s_r.data_latch <= `PPR_RST_BYTE;
      s_r.port_line_control        <= `PPR_RST_BYTE;
      s_r.extended_control        <= `PPR_RST_ECR;
      s_r.extended_index        <= `PPR_RST_3BIT;
      s_r.ctrl0      <= `PPR_RST_BYTE;
      s_r.ctrl2      <= `PPR_RST_BYTE;
      s_r.ctrl4      <= `PPR_RST_BYTE;
      s_r.cfg0       <= `PPR_RST_BYTE;
      s_r.setup      <= `PPR_RST_2BIT;
      s_r.ist        <= `PPR_RST_2BIT;
      s_r.imsk       <= `PPR_RST_2BIT;
      s_r.timeout    <= 1'b0;
      s_r.ack_d      <= 1'b1;
      s_r.xkind      <= XK_ECP_ADDRESS_FIFO;
      s_r.xwrite     <= 1'b0;
      s_r.xport      <= `PPR_RST_2BIT;
      s_r.xwdata     <= `PPR_RST_BYTE;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the slave answers in the second cycle of a local access; cable traffic adds the ready wait
  assign avs_waitrequest_o = bus_req && (s_r.state != ST_DONE);
  // readdata holds the last answer; it only means something while waitrequest is low
  assign avs_readdata_o    = {24'h000000, s_r.rdata};

  // data pins only turn round in bidirectional mode; compatibility mode always drives
  assign pd_o         = s_r.data_latch;
  assign pd_oe_o      = !dir_rev; // R01
  assign ctrl_lines_o = s_r.port_line_control[3:0];

  assign xfer_valid_o = (s_r.state == ST_XFER);
  assign xfer_kind_o  = s_r.xkind;
  assign xfer_write_o = s_r.xwrite;
  assign xfer_port_o  = s_r.xport;
  assign xfer_wdata_o = s_r.xwdata;

  assign mode_o        = mode; // R08
  assign ext_ecp_o     = s_r.setup[`PPR_SET_EXTECP] && (mode == `PPR_MODE_ECP); // R01
  assign dma_en_o      = s_r.extended_control[1]; // R08
  assign ecp_service_o = s_r.extended_control[0]; // R08
  assign ctrl0_o       = s_r.ctrl0;
  assign ctrl2_o       = s_r.ctrl2;
  assign ctrl4_o       = s_r.ctrl4;
  assign port_cfg_o    = s_r.cfg0;
  assign irq_o         = |(s_r.ist & s_r.imsk);

endmodule : ppr_top

// ==== ppr_params.svh ====
`ifndef PPR_PARAMS_SVH
`define PPR_PARAMS_SVH

// ----------------------------------------------------------------
// first level register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define PPR_IDX_DATA   11'h000
`define PPR_IDX_DSR    11'h001
`define PPR_IDX_DCR    11'h002
`define PPR_IDX_EPPA   11'h003
`define PPR_IDX_EPPD0  11'h004
`define PPR_IDX_EPPD3  11'h007
`define PPR_IDX_FIFO   11'h400
`define PPR_IDX_CFGB   11'h401
`define PPR_IDX_ECR    11'h402
`define PPR_IDX_EIR    11'h403
`define PPR_IDX_EDR    11'h404
`define PPR_IDX_EAR    11'h405
`define PPR_IDX_SETUP  11'h410
`define PPR_IDX_IST    11'h411
`define PPR_IDX_IMSK   11'h412

// ----------------------------------------------------------------
// second level offsets
// ----------------------------------------------------------------
`define PPR_SL_CTRL0   3'h0
`define PPR_SL_CTRL2   3'h2
`define PPR_SL_CTRL4   3'h4
`define PPR_SL_CFG0    3'h5

// ----------------------------------------------------------------
// mode field codes
// ----------------------------------------------------------------
`define PPR_MODE_SPP   3'h0
`define PPR_MODE_BIDIR 3'h1
`define PPR_MODE_FIFO  3'h2
`define PPR_MODE_ECP   3'h3
`define PPR_MODE_EPP   3'h4
`define PPR_MODE_TEST  3'h6
`define PPR_MODE_CFG   3'h7

// ----------------------------------------------------------------
// field positions, reset values, fixed answers
// ----------------------------------------------------------------
`define PPR_DCR_DIR    5
`define PPR_DCR_IEN    4
`define PPR_CFG0_CNFA  7
`define PPR_SET_ALIGN  0
`define PPR_SET_EXTECP 1
`define PPR_IST_TMO    0
`define PPR_IST_ACK    1
`define PPR_RST_BYTE   8'h00
`define PPR_RST_ECR    6'h00
`define PPR_RST_2BIT   2'h0
`define PPR_RST_3BIT   3'h0
`define PPR_FILL       8'hFF
`define PPR_ZERO       8'h00

`endif

// ==== ppr_pkg.sv ====
package ppr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_DONE = 3'b100
  } ppr_state_t;

  typedef enum logic [2:0] {
    XK_ECP_ADDRESS_FIFO = 3'h0,
    XK_COMPAT_FIFO = 3'h1,
    XK_ECP_DATA_FIFO = 3'h2,
    XK_TEST_FIFO = 3'h3,
    XK_EPPA  = 3'h4,
    XK_EPPD  = 3'h5
  } ppr_xkind_t;

  typedef enum logic [4:0] {
    SEL_NONE, SEL_DATA, SEL_ECP_ADDRESS_FIFO, SEL_DSR, SEL_DCR, SEL_EPPA, SEL_EPPD,
    SEL_COMPAT_FIFO, SEL_ECP_DATA_FIFO, SEL_TEST_FIFO, SEL_CFGA, SEL_CFGB, SEL_ECR, SEL_EIR,
    SEL_EDR, SEL_EAR, SEL_SETUP, SEL_IST, SEL_IMSK
  } ppr_sel_t;

  typedef struct packed {
    ppr_state_t state;
    logic [7:0] rdata;
    logic [7:0] data_latch;
    logic [7:0] port_line_control;
    logic [5:0] extended_control;
    logic [2:0] extended_index;
    logic [7:0] ctrl0;
    logic [7:0] ctrl2;
    logic [7:0] ctrl4;
    logic [7:0] cfg0;
    logic [1:0] setup;
    logic [1:0] ist;
    logic [1:0] imsk;
    logic       timeout;
    logic       ack_d;
    ppr_xkind_t xkind;
    logic       xwrite;
    logic [1:0] xport;
    logic [7:0] xwdata;
  } ppr_regs_t;

  typedef struct packed {
    logic busy;
    logic ack;
    logic pe;
    logic slct;
    logic err;
  } ppr_lines_t;

endpackage : ppr_pkg

// ==== ppr_chk.sv ====
`timescale 1ns/1ns
module ppr_chk
  import ppr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [10:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire ppr_lines_t  lines_i,
  input wire logic [7:0]  pd_o,
  input wire logic        xfer_valid_o,
  input wire ppr_xkind_t  xfer_kind_o,
  input wire logic        xfer_write_o,
  input wire logic [1:0]  xfer_port_o,
  input wire logic [7:0]  xfer_wdata_o,
  input wire logic        xfer_ready_i,
  input wire logic        fifo_full_i,
  input wire logic        fifo_empty_i,
  input wire logic [2:0]  mode_o,
  input wire logic        ext_ecp_o
);
  logic rd_ok;
  logic wr_ok;
  assign rd_ok = avs_read_i && !avs_waitrequest_o;
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_status_lines: assert property (rd_ok && avs_address_i == 11'h001
    |-> avs_readdata_o[7:3] == $past(lines_i)) else $error("status lines wrong");
  a_ecr_flags: assert property (rd_ok && avs_address_i == 11'h402
    |-> avs_readdata_o[1:0] == {$past(fifo_full_i), $past(fifo_empty_i)}) else $error("fifo flags wrong");
  a_mode_write: assert property (wr_ok && avs_address_i == 11'h402
    |=> mode_o == $past(avs_writedata_i[7:5])) else $error("mode field not written");
  a_latch_write: assert property (wr_ok && avs_address_i == 11'h000 && mode_o inside {3'h0, 3'h1}
    |=> pd_o == $past(avs_writedata_i[7:0])) else $error("data latch not written");
  a_epp_only: assert property ($rose(xfer_valid_o) && xfer_kind_o inside {XK_EPPA, XK_EPPD}
    |-> mode_o == 3'h4) else $error("epp transfer outside mode 4");
  a_ecp_address_fifo_mode: assert property (xfer_valid_o && xfer_kind_o == XK_ECP_ADDRESS_FIFO
    |-> mode_o == 3'h3 && xfer_write_o) else $error("address fifo misuse");
  a_xfer_hold: assert property (xfer_valid_o && !xfer_ready_i
    |=> xfer_valid_o && $stable(xfer_kind_o) && $stable(xfer_wdata_o) && $stable(xfer_port_o))
    else $error("transfer dropped or changed");
  a_refuse_fill: assert property (rd_ok && avs_address_i inside {[11'h003:11'h007]} && mode_o != 3'h4
    |-> avs_readdata_o == 32'h000000FF) else $error("refused read not fixed value");
  a_ext_ecp: assert property (ext_ecp_o |-> mode_o == 3'h3) else $error("extended ecp outside ecp");
endmodule : ppr_chk

bind ppr_top ppr_chk i_chk (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .lines_i(lines_i), .pd_o(pd_o), .xfer_valid_o(xfer_valid_o),
  .xfer_kind_o(xfer_kind_o), .xfer_write_o(xfer_write_o), .xfer_port_o(xfer_port_o),
  .xfer_wdata_o(xfer_wdata_o), .xfer_ready_i(xfer_ready_i), .fifo_full_i(fifo_full_i),
  .fifo_empty_i(fifo_empty_i), .mode_o(mode_o), .ext_ecp_o(ext_ecp_o));

// ==== ppr_cable_mdl.sv ====
`timescale 1ns/1ns
module ppr_cable_mdl
  import ppr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        valid_i,
  input  wire ppr_xkind_t  kind_i,
  input  wire logic        write_i,
  input  wire logic [1:0]  port_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [1:0]  lag_i,
  input  wire logic        tmo_i,
  output logic             ready_o,
  output logic      [7:0]  rdata_o,
  output logic             tmo_o,
  output logic      [13:0] seen_o
);
  logic [1:0] wait_r;
  logic [7:0] spin_r;
  // lines move every cycle outside the answer so a stale sample is caught
  assign rdata_o = ready_o ? (8'hC0 | 8'(kind_i)) : spin_r;
  assign tmo_o   = ready_o && tmo_i;
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      wait_r  <= 2'h0;
      ready_o <= 1'b0;
      spin_r  <= 8'h00;
      seen_o  <= 14'h0000;
    end
    else
    begin
      spin_r  <= spin_r + 8'h01;
      ready_o <= valid_i && !ready_o && wait_r == lag_i;
      wait_r  <= (valid_i && !ready_o && wait_r != lag_i) ? wait_r + 2'h1 : 2'h0;
      if (valid_i && ready_o)
        seen_o <= {kind_i, write_i, port_i, wdata_i};
    end
endmodule : ppr_cable_mdl

// ==== parallel_port_register_decode_tb.sv ====
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module parallel_port_register_decode_tb
  import ppr_pkg::*;
;
  logic clk_i = 1'b0, resetn_i = 1'b0, rd = 1'b0, wr = 1'b0, wreq, xv, xw, rdy, mtmo, irq, tmo = 1'b0;
  logic ffull = 1'b0, fempty = 1'b0, ftag = 1'b0, oe, ext, dma, svc;
  logic [3:0] ctl;
  logic [10:0] adr = 11'h000;
  logic [31:0] wd = 32'h0, rdat, seed = 32'h0000AE0B;
  logic [7:0] pd_in = 8'h00, pd_q, xd, mrd, c0, c2, c4, cf, d;
  logic [7:0] sl [8];
  logic [1:0] xp, lag = 2'h0;
  logic [2:0] mode, k;
  logic [13:0] seen;
  ppr_lines_t lines = '0;
  ppr_xkind_t xk;
  int bad_count = 0, checks_done = 0, m, p;
  always #25 clk_i = ~clk_i;
  ppr_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .lines_i(lines), .pd_i(pd_in), .pd_o(pd_q), .pd_oe_o(oe), .ctrl_lines_o(ctl),
    .xfer_valid_o(xv), .xfer_kind_o(xk), .xfer_write_o(xw), .xfer_port_o(xp), .xfer_wdata_o(xd),
    .xfer_ready_i(rdy), .xfer_rdata_i(mrd), .xfer_timeout_i(mtmo), .fifo_full_i(ffull),
    .fifo_empty_i(fempty), .fifo_tag_i(ftag), .mode_o(mode), .ext_ecp_o(ext), .dma_en_o(dma),
    .ecp_service_o(svc), .ctrl0_o(c0), .ctrl2_o(c2), .ctrl4_o(c4), .port_cfg_o(cf), .irq_o(irq));
  ppr_cable_mdl i_mdl (.clk_i(clk_i), .resetn_i(resetn_i), .valid_i(xv), .kind_i(xk), .write_i(xw),
    .port_i(xp), .wdata_i(xd), .lag_i(lag), .tmo_i(tmo), .ready_o(rdy), .rdata_o(mrd), .tmo_o(mtmo),
    .seen_o(seen));
  // ----------------------------------------------------------------
  // bus and check helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic [10:0] a, input logic [7:0] v, output logic [7:0] q);
    int n;
    n = 0;
    adr <= a;
    wd <= {24'h0, v};
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 300);
    if (n >= 300)
      `CHK("waitrequest", 1'b0, wreq)
    q = rdat[7:0];
    if (!w)
      `CHK("upper", 24'h0, rdat[31:8])
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wrt(input logic [10:0] a, input logic [7:0] v);
    logic [7:0] q;
    bus(1'b1, a, v, q);
  endtask : wrt
  task automatic rdc(input string n, input logic [10:0] a, input logic [7:0] e, input logic [7:0] mk);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(n, e & mk, q & mk)
  endtask : rdc
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    lines <= ppr_lines_t'(xs());
    {ffull, fempty, ftag} <= 3'(xs());
    pd_in <= 8'(xs());
    @(posedge clk_i);
    rdc("ecr", 11'h402, {6'h00, ffull, fempty}, 8'hFF);
    rdc("status", 11'h001, {lines, 3'h0}, 8'hF9);
    wrt(11'h001, 8'hFF);
    rdc("status ro", 11'h001, {lines, 3'h0}, 8'hF9);
    for (m = 0; m < 8; m++)
    begin
      lag <= 2'(m);
      wrt(11'h402, {3'(m), 5'h00});
      `CHK("mode", 3'(m), mode)
      k = (m == 2) ? 3'h1 : (m == 3) ? 3'h2 : 3'h3;
      if (m < 2)
      begin
        d = 8'(xs());
        wrt(11'h000, d);
        rdc("latch", 11'h000, d, 8'hFF);
        `CHK("pins", d, pd_q)
      end
      rdc("fifo400", 11'h400, (m == 3 || m == 6) ? (8'hC0 | k) : (m == 7) ? 8'h00 : 8'hFF,
          (m == 7) ? 8'h08 : 8'hFF);
      if (m == 2 || m == 3 || m == 6)
      begin
        d = 8'(xs());
        wrt(11'h400, d);
        `CHK("fifo xfer", {k, 1'b1, d}, {seen[13:10], seen[7:0]})
      end
      if (m == 3)
      begin
        wrt(11'h410, 8'h02);
        d = 8'(xs());
        wrt(11'h000, d);
        `CHK("addr xfer", {3'h0, 1'b1, d}, {seen[13:10], seen[7:0]})
        rdc("addr wo", 11'h000, 8'hFF, 8'hFF);
        rdc("epp off", 11'h005, 8'hFF, 8'hFF);
      end
    end
    wrt(11'h402, 8'h80);
    rdc("epp unal", 11'h004, 8'hFF, 8'hFF);
    wrt(11'h403, 8'h00);
    wrt(11'h404, 8'h5A);
    rdc("edr unal", 11'h404, 8'hFF, 8'hFF);
    `CHK("ctrl0 unal", 8'h00, c0)
    wrt(11'h410, 8'h01);
    for (p = 0; p < 5; p++)
    begin
      lag <= 2'(p);
      k = (p == 0) ? 3'h4 : 3'h5;
      d = 8'(xs());
      wrt(11'(3 + p), d);
      `CHK("epp xfer", {k, 1'b1, d}, {seen[13:10], seen[7:0]})
      if (p > 0)
        `CHK("epp port", 2'(p - 1), seen[9:8])
      rdc("epp rd", 11'(3 + p), 8'hC0 | k, 8'hFF);
    end
    for (m = 0; m < 8; m++)
    begin
      d = 8'(xs());
      sl[m] = (m == 0 || m == 2 || m == 4 || m == 5) ? d : 8'hFF;
      wrt(11'h403, 8'(m));
      wrt(11'h404, d);
    end
    for (m = 0; m < 8; m++)
    begin
      wrt(11'h403, 8'(m));
      rdc("second", 11'h404, sl[m], 8'hFF);
    end
    `CHK("outs", {sl[0], sl[2], sl[4], sl[5]}, {c0, c2, c4, cf})
    wrt(11'h412, 8'h01);
    tmo <= 1'b1;
    wrt(11'h003, 8'h3C);
    tmo <= 1'b0;
    `CHK("irq set", 1'b1, irq)
    rdc("tmo set", 11'h001, 8'h01, 8'h01);
    rdc("tmo clr", 11'h001, 8'h00, 8'h01);
    wrt(11'h411, 8'h01);
    `CHK("irq clr", 1'b0, irq)
    wrt(11'h402, 8'h2C);
    wrt(11'h002, 8'h3A);
    `CHK("ctl outs", 7'b0101011, {oe, ctl, dma, svc})
    rdc("reverse", 11'h000, pd_in, 8'hFF);
    rdc("dcr", 11'h002, 8'h3A, 8'hFF);
    wrt(11'h412, 8'h02);
    lines.ack <= 1'b1;
    @(posedge clk_i);
    lines.ack <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("irq ack", 1'b1, irq)
    rdc("tag", 11'h405, {ftag, 7'h00}, 8'hFF);
    wrt(11'h410, 8'h03);
    wrt(11'h402, 8'h60);
    `CHK("ext ecp", 1'b1, ext)
    wrt(11'h402, 8'hE0);
    rdc("cfgb", 11'h401, {2'b01, sl[5][5:3], 1'b0, sl[5][1:0]}, 8'hFF);
    rdc("unmapped", 11'h7FF, 8'hFF, 8'hFF);
    complete_run();
  end
endmodule : parallel_port_register_decode_tb
